//--- bench/acc_cmp_model.sv
// behavioural analog comparator at the far side of the control block
`timescale 1ns/100ps
`default_nettype none
module acc_cmp_model #(
  parameter logic [7:0] BANDGAP = 8'hA0
) (
  input  wire logic [7:0] pos_i,
  input  wire logic [7:0] neg_i,
  input  wire logic       ref_sel_i,
  input  wire logic       enable_i,
  output logic            cmp_o
);
  // ==========================================
  // compare
  // input pick, compare
  assign cmp_o = enable_i & ((ref_sel_i ? BANDGAP : pos_i) > neg_i);
endmodule : acc_cmp_model
`default_nettype wire

//--- bench/acc_top_tb.sv
// testbench for the analog compare control block
`timescale 1ns/100ps
`default_nettype none
module acc_top_tb
  import acc_pkg::*;
;
  logic       clk_i, rst_b_i, wr_i, rd_i, deep_stop_i, cmp, ref_sel, aen;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pos;
  logic       pin_o, pin_oe, irq_o, wake_o;
  int         n_errors, total_checks;
  // ==========================================
  // instances
  acc_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .cmp_out_i(cmp), .deep_stop_i(deep_stop_i),
    .rdata_o(rdata_o), .reference_select_o(ref_sel), .analog_enable_o(aen),
    .compare_out_pin_o(pin_o), .compare_out_pin_oe_o(pin_oe), .irq_o(irq_o),
    .wake_o(wake_o));
  acc_cmp_model u_cmp (.pos_i(pos), .neg_i(8'h80), .ref_sel_i(ref_sel), .enable_i(aen),
    .cmp_o(cmp));
  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
  endtask : rd
  task automatic step(input logic [7:0] v);
    pos <= v;
    repeat (6) @(posedge clk_i);
  endtask : step
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // ==========================================
  // clock, watchdog; reset is driven by the tests
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    complete_run;
  end
  // ==========================================
  // tests
  initial begin
    {rst_b_i, wr_i, rd_i, deep_stop_i, addr_i, wdata_i, pos} = '0;
    pos = 8'h40;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h95);
    rd(4'h0, 8'h95);
    chk("aen", aen, 8'h01);
    step(8'hC0);
    rd(4'h0, 8'hBD);
    chk("irq", {irq_o, wake_o, pin_oe}, 8'h07);
    wr(4'h0, 8'hB5);
    rd(4'h0, 8'h9D);
    chk("pin", {irq_o, pin_o, pin_oe}, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 8'hA0 | m);
      step(8'h40);
      rd(4'h0, 8'h80 | m | ((m != 1) ? 8'h20 : 8'h00));
      wr(4'h0, 8'hA0 | m);
      step(8'hC0);
      rd(4'h0, 8'h88 | m | ((m % 2) ? 8'h20 : 8'h00));
    end
    wr(4'h2, 8'h01);
    #1 chk("irq", irq_o, 8'h01);
    wr(4'h1, 8'h03);
    rd(4'h1, 8'h00);
    chk("irq", irq_o, 8'h00);
    wr(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    step(8'h40);
    wr(4'h0, 8'hE1);
    repeat (6) @(posedge clk_i);
    rd(4'h0, 8'hE9);
    chk("ref", ref_sel, 8'h01);
    // disabled when not a wake source
    wr(4'h0, 8'h23);
    step(8'hC0);
    step(8'h40);
    rd(4'h0, 8'h03);
    wr(4'h0, 8'h97);
    deep_stop_i <= 1'b1;
    @(posedge clk_i);
    deep_stop_i <= 1'b0;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h97);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, 8'h00);
    complete_run;
  end
endmodule : acc_top_tb
`default_nettype wire

//--- hw/acc_defs.svh
// constants for the analog compare control block
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_ADDR_W        4
`define ACC_OFF_CSC       4'h0
`define ACC_OFF_IRQ_STAT  4'h1
`define ACC_OFF_IRQ_MASK  4'h2
`define ACC_BIT_ENABLE    7
`define ACC_BIT_REFSEL    6
`define ACC_BIT_FLAG      5
`define ACC_BIT_IRQ_EN    4
`define ACC_BIT_LEVEL     3
`define ACC_BIT_PIN_EN    2
`define ACC_CSC_RESET     8'h00
`define ACC_WR_MASK       8'hD7
`define ACC_SYNC_STAGES   2
`endif

//--- hw/acc_edge.sv
// edge detector on the synchronised comparator level
`timescale 1ns/100ps
`default_nettype none
module acc_edge
  import acc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic level_i,
  output acc_edge_t edge_o
);
  logic prev_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= enable_i & level_i;
    end
  end

  // edges only while enabled, prev cleared when disabled
  assign edge_o = {enable_i & level_i & ~prev_q, enable_i & ~level_i & prev_q};
endmodule : acc_edge
`default_nettype wire

//--- hw/acc_pkg.sv
// types for the analog compare control block
`include "acc_defs.svh"
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_MODE_FALL0 = 2'b00,
    ACC_MODE_RISE  = 2'b01,
    ACC_MODE_FALL2 = 2'b10,
    ACC_MODE_BOTH  = 2'b11
  } acc_mode_t;

  typedef struct packed {
    logic      module_enable_bit;
    logic      reference_select_bit;
    logic      compare_event_flag;
    logic      compare_irq_enable;
    logic      output_level_bit;
    logic      output_pin_enable;
    acc_mode_t edge_mode_field;
  } acc_csc_t;

  typedef struct packed {
    logic [`ACC_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } acc_bus_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } acc_edge_t;
endpackage : acc_pkg

//--- hw/acc_sync.sv
// two-stage synchroniser for the comparator output
`timescale 1ns/100ps
`default_nettype none
module acc_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [STAGES-1:0] chain_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_i};
    end
  end

  assign sync_o = chain_q[STAGES-1];
endmodule : acc_sync
`default_nettype wire

//--- hw/acc_top.sv
// register, flag and interrupt logic around the analog comparator
`timescale 1ns/100ps
`default_nettype none
`include "acc_defs.svh"

// Behaviour
// (R1) bit 7 enables module, no events otherwise
// (R2) bit 6 selects pin or bandgap input
// (R3) bit 5 flag sticky, write one clears
// (R4) bit 4 gates interrupt from flag
// (R5) bit 3 reads live level, zero disabled
// (R6) bit 2 routes output to pin
// (R7) bits 1:0 choose falling, rising, either edge
// (R8) output high when positive exceeds negative
// (R9) keeps running in wait, irq wakes
// (R10) stop3 keeps comparing, pin, flag, wake
// (R11) reset exit restores reset state
// (R12) deep stop leaves block in reset
// (R13) debug halt changes nothing
// (R14) software disables before wait if unused
// (R15) single 8-bit control and status register; the block also has irq status and irq mask registers at offsets 1 and 2
// (R16) software sets bandgap buffer with reference
// (R17) comparator output synchronised two flops
module acc_top
  import acc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [`ACC_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  input  wire logic                   cmp_out_i,
  input  wire logic                   deep_stop_i,
  output logic [7:0]                  rdata_o,
  output logic                        reference_select_o,
  output logic                        analog_enable_o,
  output logic                        compare_out_pin_o,
  output logic                        compare_out_pin_oe_o,
  output logic                        irq_o,
  output logic                        wake_o
);
  // ==========================================================
  // state
  typedef struct packed {
    acc_csc_t   csc;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic       pin;
    logic       pin_oe;
    logic       irq;
    logic       ref_sel;
    logic       ana_en;
  } acc_state_t;

  acc_state_t s_q;
  acc_state_t s_d;
  acc_bus_t   bus;
  acc_edge_t  edg;
  logic       level_sync;
  logic       cmp_event;
  logic       flag_irq;

  assign bus = {addr_i, wdata_i, wr_i, rd_i};

  // ==========================================================
  // comparator input path
  // (R8) level high when positive above negative
  // (R17) two-flop synchroniser
  acc_sync #(
    .STAGES (`ACC_SYNC_STAGES)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (cmp_out_i),
    .sync_o  (level_sync)
  );

  // (R1) edges need enable
  acc_edge u_edge (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .enable_i (s_q.csc.module_enable_bit),
    .level_i  (level_sync),
    .edge_o   (edg)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    // (R7) event by edge mode
    unique case (s_q.csc.edge_mode_field)
      ACC_MODE_FALL0: cmp_event = edg.fall;
      ACC_MODE_RISE:  cmp_event = edg.rise;
      ACC_MODE_FALL2: cmp_event = edg.fall;
      ACC_MODE_BOTH:  cmp_event = edg.rise | edg.fall;
    endcase
    // (R15) single control register writes
    if (bus.wr && bus.addr == `ACC_OFF_CSC) begin
      s_d.csc = acc_csc_t'((bus.wdata & `ACC_WR_MASK) |
                           ({s_q.csc} & ~`ACC_WR_MASK));
      // (R3) write one clears flag
      if (bus.wdata[`ACC_BIT_FLAG]) begin
        s_d.csc.compare_event_flag = 1'b0;
      end
    end
    // (R3) set wins over clear
    if (cmp_event) begin
      s_d.csc.compare_event_flag = 1'b1;
    end
    // (R5) live level, zero when disabled
    s_d.csc.output_level_bit = s_d.csc.module_enable_bit & level_sync;
    // interrupt status: bit0 event, bit1 level change
    if (bus.wr && bus.addr == `ACC_OFF_IRQ_STAT) begin
      s_d.stat = s_q.stat & ~bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == `ACC_OFF_IRQ_MASK) begin
      s_d.mask = bus.wdata[1:0];
    end
    s_d.stat = s_d.stat | {edg.rise | edg.fall, cmp_event};
    // read data one cycle later
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `ACC_OFF_CSC:      s_d.rdata = s_q.csc;
        `ACC_OFF_IRQ_STAT: s_d.rdata = {6'h00, s_q.stat};
        `ACC_OFF_IRQ_MASK: s_d.rdata = {6'h00, s_q.mask};
        default:           s_d.rdata = 8'h00;
      endcase
    end
    // (R6) pin driven only when routed
    s_d.pin_oe = s_d.csc.module_enable_bit & s_d.csc.output_pin_enable;
    s_d.pin    = s_d.pin_oe & s_d.csc.output_level_bit;
    // (R2) non-inverting input select
    s_d.ref_sel = s_d.csc.reference_select_bit;
    s_d.ana_en  = s_d.csc.module_enable_bit;
    // (R4) flag gated by irq enable
    s_d.irq = (s_d.csc.compare_event_flag & s_d.csc.compare_irq_enable) |
              (|(s_d.stat & s_d.mask));
  end

  assign flag_irq = s_q.csc.compare_event_flag & s_q.csc.compare_irq_enable;

  // ==========================================================
  // registers
  // (R13) no debug input, logic always runs
  // (R11) reset restores state; (R12) deep stop resets
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || deep_stop_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o              = s_q.rdata;
  assign reference_select_o   = s_q.ref_sel;
  assign analog_enable_o      = s_q.ana_en;
  assign compare_out_pin_o    = s_q.pin;
  assign compare_out_pin_oe_o = s_q.pin_oe;
  assign irq_o                = s_q.irq;
  // (R9) wake in wait and stop3; (R10)
  assign wake_o               = s_q.irq;

  // ==========================================================
  // assertions
  sequence rise_seen_s;
    s_q.csc.module_enable_bit && edg.rise && !deep_stop_i;
  endsequence

  flag_sets_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R3)
    rise_seen_s ##0 (s_q.csc.edge_mode_field == ACC_MODE_RISE)
    |=> s_q.csc.compare_event_flag) else $error("flag not set on rise");

  flag_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R3)
    s_q.csc.compare_event_flag && !(wr_i && addr_i == `ACC_OFF_CSC) && !deep_stop_i
    |=> s_q.csc.compare_event_flag) else $error("flag dropped");

  no_event_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R1)
    !s_q.csc.module_enable_bit |-> !cmp_event) else $error("event while disabled");

  level_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R5)
    !s_q.csc.module_enable_bit |-> !s_q.csc.output_level_bit)
    else $error("level not zero");

  irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R4)
    flag_irq && !deep_stop_i |=> irq_o || !s_q.csc.compare_event_flag
    || !s_q.csc.compare_irq_enable) else $error("irq missing");

  pin_route_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R6)
    !s_q.csc.output_pin_enable |-> !compare_out_pin_oe_o) else $error("pin driven");

  fall_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R7)
    edg.rise && s_q.csc.edge_mode_field == ACC_MODE_FALL2 |-> !cmp_event)
    else $error("rise in fall mode");

  deep_reset_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R12)
    deep_stop_i |=> s_q.csc == `ACC_CSC_RESET) else $error("no reset after deep stop");

  ref_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // (R2)
    reference_select_o == s_q.csc.reference_select_bit) else $error("ref select stale");
endmodule : acc_top
`default_nettype wire
